/* File: mrs_pkg.sv */
// Purpose: Shared constants and types for the rotate, subtract and skip
//          execution core of an 8-bit controller.
// Assumes: APB slave with a 12-bit byte address and 32-bit data.
// Notes:   Every register holds one aligned word; narrow data sits low.
package mrs_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses.
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CMD = 12'h000;
   localparam logic [11:0] ADDR_ACC = 12'h004;
   localparam logic [11:0] ADDR_FLAGS = 12'h008;
   localparam logic [11:0] ADDR_STATUS = 12'h00C;
   localparam logic [11:0] ADDR_MEM_BASE = 12'h040;
   localparam int unsigned MEM_WORDS = 16;

   // ----------------------------------------------------------------
   // Field positions and reset values.
   // ----------------------------------------------------------------
   localparam int unsigned FLG_CARRY = 0;
   localparam int unsigned FLG_AUX = 1;
   localparam int unsigned FLG_ZERO = 2;
   localparam int unsigned FLG_OVER = 3;
   localparam int unsigned STS_BUSY = 0;
   localparam int unsigned STS_SKIP = 1;
   localparam int unsigned STS_CYC_LSB = 4;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [7:0] MEM_RST = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [7:0] BYTE_ONE = 8'h01;

   // Execution time in instruction cycles, as reported in STATUS.
   localparam logic [1:0] CYC_PLAIN = 2'h1;
   localparam logic [1:0] CYC_SKIP = 2'h2;

   // ----------------------------------------------------------------
   // Operation codes.
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_ROTL_CARRY_MEM = 5'h00,
      OP_ROTL_CARRY_ACC = 5'h01,
      OP_ROTR_MEM = 5'h02,
      OP_ROTR_ACC = 5'h03,
      OP_ROTR_CARRY_MEM = 5'h04,
      OP_ROTR_CARRY_ACC = 5'h05,
      OP_SUB_BORROW_ACC = 5'h06,
      OP_SUB_BORROW_MEM = 5'h07,
      OP_DEC_SKIP_MEM = 5'h08,
      OP_DEC_SKIP_ACC = 5'h09,
      OP_SET_BYTE = 5'h0A,
      OP_SET_BIT = 5'h0B,
      OP_INC_SKIP_MEM = 5'h0C,
      OP_INC_SKIP_ACC = 5'h0D,
      OP_SKIP_BIT_SET = 5'h0E,
      OP_SUB_ACC = 5'h0F,
      OP_SUB_MEM = 5'h10,
      OP_SUB_IMM = 5'h11,
      OP_SWAP_MEM = 5'h12,
      OP_SWAP_ACC = 5'h13
   } mrs_op_t;
   localparam logic [4:0] OP_LAST = 5'h13;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_DUMMY = 3'b100
   } mrs_state_t;

   // ----------------------------------------------------------------
   // Carriers.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic overflow_flag;
      logic zero_flag;
      logic aux_carry_flag;
      logic carry_flag;
   } mrs_flags_t;

   typedef struct packed {
      logic [7:0] imm;
      logic [3:0] rsv_hi;
      logic [3:0] addr;
      logic [4:0] rsv_mid;
      logic [2:0] bit_sel;
      logic [2:0] rsv_lo;
      logic [4:0] op;
   } mrs_cmd_t;

   typedef struct packed {
      logic [7:0] value;
      mrs_flags_t flags;
   } mrs_alu_t;

endpackage : mrs_pkg

/* File: mrs_exec_core.sv */
// Purpose: Execution core for rotates, subtracts, set, skip and swap
//          operations of an 8-bit controller, driven over APB.
// Assumes: One clock, clk_sys at 100 MHz; rst asynchronous, active high.
// Notes:   Writing CMD starts one operation on a small local data memory.
//
// Overview of operation
// [RULE_01] Rotate-left-carry memory: carry in bit 0.
// [RULE_02] Rotate-left-carry to accumulator, memory kept.
// [RULE_03] Rotate right in memory, flags kept.
// [RULE_04] Rotate right to accumulator, memory kept.
// [RULE_05] Rotate-right-carry memory: carry in bit 7.
// [RULE_06] Rotate-right-carry to accumulator, memory kept.
// [RULE_07] Subtract with borrow into accumulator, four flags.
// [RULE_08] Subtract with borrow into memory, four flags.
// [RULE_09] Decrement memory, skip on zero, two cycles.
// [RULE_10] Decrement to accumulator, skip on zero.
// [RULE_11] Set byte writes all ones.
// [RULE_12] Set selected bit, others kept.
// [RULE_13] Increment memory, skip on zero, two cycles.
// [RULE_14] Increment to accumulator, skip on zero.
// [RULE_15] Skip when selected bit is one.
// [RULE_16] Subtract memory into accumulator, four flags.
// [RULE_17] Subtract memory into memory, four flags.
// [RULE_18] Subtract immediate from accumulator, four flags.
// [RULE_19] Swap nibbles in memory, flags kept.
// [RULE_20] Swap nibbles to accumulator, memory kept.
// [RULE_21] Carry means no borrow; zero on zero.
//
// Chosen here: the register addresses and the APB slave port.
module mrs_exec_core (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic busy,
   output logic last_skip
);

   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   mrs_pkg::mrs_state_t state_reg;
   mrs_pkg::mrs_state_t state_next;
   mrs_pkg::mrs_cmd_t cmd_reg;
   mrs_pkg::mrs_flags_t flags_reg;
   logic [7:0] acc_reg;
   logic [7:0] mem_reg [mrs_pkg::MEM_WORDS];
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic busy_reg;
   logic skip_reg;
   logic [1:0] cycles_reg;

   // ----------------------------------------------------------------
   // Arithmetic shared by all subtract forms and by the checks.
   // ----------------------------------------------------------------
   // Subtraction is done as a + ~b + cin so carry set means no borrow.
   function automatic mrs_pkg::mrs_alu_t sub_add(
      input logic [7:0] a,
      input logic [7:0] b,
      input logic cin
   );
      logic [8:0] full;
      logic [4:0] low;
      mrs_pkg::mrs_alu_t r;
      full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      r.value = full[7:0];
      r.flags.carry_flag = full[8];
      r.flags.aux_carry_flag = low[4];
      r.flags.zero_flag = (full[7:0] == 8'h00);
      r.flags.overflow_flag = (a[7] == ~b[7]) && (full[7] != a[7]);
      return r;
   endfunction : sub_add

   // ----------------------------------------------------------------
   // APB decode.
   // ----------------------------------------------------------------
   logic sel_cmd;
   logic sel_acc;
   logic sel_flags;
   logic sel_status;
   logic sel_mem;
   logic mapped;
   logic [3:0] mem_idx;
   logic apb_done;
   logic wr_fire;
   logic start;
   logic [31:0] cmd_merged;
   logic [31:0] rd_mux;

   // Decode is purely on the held address; the bus keeps it stable.
   always_comb
   begin
      sel_cmd = (paddr == mrs_pkg::ADDR_CMD);
      sel_acc = (paddr == mrs_pkg::ADDR_ACC);
      sel_flags = (paddr == mrs_pkg::ADDR_FLAGS);
      sel_status = (paddr == mrs_pkg::ADDR_STATUS);
      sel_mem = (paddr[11:6] == mrs_pkg::ADDR_MEM_BASE[11:6]) &&
                (paddr[1:0] == 2'b00);
      mem_idx = paddr[5:2];
      mapped = sel_cmd | sel_acc | sel_flags | sel_status | sel_mem;
   end

   // A transfer completes on the edge where pready is seen high.
   assign apb_done = psel & penable & pready_reg;
   assign wr_fire = apb_done & pwrite & ~pslverr_reg;

   // Byte lanes are merged into the held command before it starts.
   always_comb
   begin
      cmd_merged = cmd_reg;
      for (int i = 0; i < 4; i++)
      begin
         if (pstrb[i])
         begin
            cmd_merged[8*i +: 8] = pwdata[8*i +: 8];
         end
      end
   end
   assign start = wr_fire & sel_cmd & (cmd_merged[4:0] <= mrs_pkg::OP_LAST);

   // Read data; unmapped addresses return zero with an error.
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (sel_cmd)
      begin
         rd_mux = cmd_reg;
      end
      else if (sel_acc)
      begin
         rd_mux = {24'h00_0000, acc_reg};
      end
      else if (sel_flags)
      begin
         rd_mux = {28'h000_0000, flags_reg};
      end
      else if (sel_status)
      begin
         rd_mux = {26'h000_0000, cycles_reg, 2'b00, skip_reg, busy_reg};
      end
      else if (sel_mem)
      begin
         rd_mux = {24'h00_0000, mem_reg[mem_idx]};
      end
   end

   // The answer waits while an operation runs, so bus traffic never
   // races the engine for the accumulator, flags or memory.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end
      else
      begin
         pready_reg <= psel & penable & ~pready_reg &
                       (state_reg == mrs_pkg::ST_IDLE);
         // The error pulse rides with pready, never ahead of it.
         pslverr_reg <= psel & penable & ~pready_reg & ~mapped &
                        (state_reg == mrs_pkg::ST_IDLE);
         if (psel & penable & ~pready_reg)
         begin
            prdata_reg <= (pwrite | ~mapped) ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Datapath for the running operation.
   // ----------------------------------------------------------------
   logic [7:0] operand;
   logic cin;
   logic [7:0] ex_val;
   logic ex_to_mem;
   logic ex_to_acc;
   logic ex_skip;
   mrs_pkg::mrs_flags_t ex_flags;
   mrs_pkg::mrs_alu_t alu;
   logic [7:0] alu_a;
   logic [7:0] alu_b;
   logic alu_cin;

   assign operand = mem_reg[cmd_reg.addr];
   assign cin = flags_reg.carry_flag;
   // Operands are picked outside the decode so the adder never loops
   // back into the process that reads its result.
   assign alu_a = acc_reg;
   assign alu_b = (cmd_reg.op == mrs_pkg::OP_SUB_IMM) ?
                  cmd_reg.imm : operand;                        // RULE_18
   assign alu_cin = (cmd_reg.op == mrs_pkg::OP_SUB_BORROW_ACC ||
                     cmd_reg.op == mrs_pkg::OP_SUB_BORROW_MEM) ?
                    cin : 1'b1;                                 // RULE_07
   assign alu = sub_add(alu_a, alu_b, alu_cin);

   // One decode selects the result, its destination, flags and skip.
   always_comb
   begin
      ex_val = operand;
      ex_to_mem = 1'b0;
      ex_to_acc = 1'b0;
      ex_skip = 1'b0;
      ex_flags = flags_reg;
      unique case (mrs_pkg::mrs_op_t'(cmd_reg.op))
         mrs_pkg::OP_ROTL_CARRY_MEM, mrs_pkg::OP_ROTL_CARRY_ACC:
         begin
            ex_val = {operand[6:0], cin};                       // RULE_01
            ex_flags.carry_flag = operand[7];                   // RULE_02
            ex_to_mem = (cmd_reg.op == mrs_pkg::OP_ROTL_CARRY_MEM);
            ex_to_acc = ~ex_to_mem;
         end
         mrs_pkg::OP_ROTR_MEM, mrs_pkg::OP_ROTR_ACC:
         begin
            ex_val = {operand[0], operand[7:1]};                // RULE_03
            ex_to_mem = (cmd_reg.op == mrs_pkg::OP_ROTR_MEM);
            ex_to_acc = ~ex_to_mem;                             // RULE_04
         end
         mrs_pkg::OP_ROTR_CARRY_MEM, mrs_pkg::OP_ROTR_CARRY_ACC:
         begin
            ex_val = {cin, operand[7:1]};                       // RULE_05
            ex_flags.carry_flag = operand[0];                   // RULE_06
            ex_to_mem = (cmd_reg.op == mrs_pkg::OP_ROTR_CARRY_MEM);
            ex_to_acc = ~ex_to_mem;
         end
         mrs_pkg::OP_SUB_BORROW_ACC, mrs_pkg::OP_SUB_BORROW_MEM:
         begin
            ex_val = alu.value;                                 // RULE_07
            ex_flags = alu.flags;                               // RULE_21
            ex_to_mem = (cmd_reg.op == mrs_pkg::OP_SUB_BORROW_MEM);
            ex_to_acc = ~ex_to_mem;                             // RULE_08
         end
         mrs_pkg::OP_DEC_SKIP_MEM, mrs_pkg::OP_DEC_SKIP_ACC:
         begin
            ex_val = operand - mrs_pkg::BYTE_ONE;               // RULE_09
            ex_skip = (ex_val == 8'h00);
            ex_to_mem = (cmd_reg.op == mrs_pkg::OP_DEC_SKIP_MEM);
            ex_to_acc = ~ex_to_mem;                             // RULE_10
         end
         mrs_pkg::OP_SET_BYTE:
         begin
            ex_val = mrs_pkg::BYTE_ONES;                        // RULE_11
            ex_to_mem = 1'b1;
         end
         mrs_pkg::OP_SET_BIT:
         begin
            ex_val = operand | (8'h01 << cmd_reg.bit_sel);      // RULE_12
            ex_to_mem = 1'b1;
         end
         mrs_pkg::OP_INC_SKIP_MEM, mrs_pkg::OP_INC_SKIP_ACC:
         begin
            ex_val = operand + mrs_pkg::BYTE_ONE;               // RULE_13
            ex_skip = (ex_val == 8'h00);
            ex_to_mem = (cmd_reg.op == mrs_pkg::OP_INC_SKIP_MEM);
            ex_to_acc = ~ex_to_mem;                             // RULE_14
         end
         mrs_pkg::OP_SKIP_BIT_SET:
         begin
            ex_skip = operand[cmd_reg.bit_sel];                 // RULE_15
         end
         mrs_pkg::OP_SUB_ACC, mrs_pkg::OP_SUB_MEM:
         begin
            ex_val = alu.value;                                 // RULE_16
            ex_flags = alu.flags;                               // RULE_21
            ex_to_mem = (cmd_reg.op == mrs_pkg::OP_SUB_MEM);    // RULE_17
            ex_to_acc = ~ex_to_mem;
         end
         mrs_pkg::OP_SUB_IMM:
         begin
            ex_val = alu.value;                                 // RULE_18
            ex_flags = alu.flags;
            ex_to_acc = 1'b1;
         end
         mrs_pkg::OP_SWAP_MEM, mrs_pkg::OP_SWAP_ACC:
         begin
            ex_val = {operand[3:0], operand[7:4]};              // RULE_19
            ex_to_mem = (cmd_reg.op == mrs_pkg::OP_SWAP_MEM);
            ex_to_acc = ~ex_to_mem;                             // RULE_20
         end
         default:
         begin
            ex_val = operand;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer: one execute cycle, plus a dummy cycle on a skip.
   // ----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         mrs_pkg::ST_IDLE:
         begin
            if (start)
            begin
               state_next = mrs_pkg::ST_EXEC;
            end
         end
         mrs_pkg::ST_EXEC:
         begin
            // The discarded prefetch costs one extra cycle.
            state_next = ex_skip ? mrs_pkg::ST_DUMMY : mrs_pkg::ST_IDLE;
         end
         mrs_pkg::ST_DUMMY:
         begin
            state_next = mrs_pkg::ST_IDLE;
         end
         default:
         begin
            state_next = mrs_pkg::ST_IDLE;
         end
      endcase
   end

   // State, busy and the cycle report for the last operation.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= mrs_pkg::ST_IDLE;
         busy_reg <= 1'b0;
         skip_reg <= 1'b0;
         cycles_reg <= 2'h0;
      end
      else
      begin
         state_reg <= state_next;
         busy_reg <= (state_next != mrs_pkg::ST_IDLE);
         if (state_reg == mrs_pkg::ST_EXEC)
         begin
            skip_reg <= ex_skip;                      // RULE_09
            cycles_reg <= ex_skip ? mrs_pkg::CYC_SKIP : mrs_pkg::CYC_PLAIN;
         end
      end
   end

   // Command register; only legal codes are accepted and started.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         cmd_reg <= '0;
      end
      else if (start)
      begin
         cmd_reg <= cmd_merged;
      end
   end

   // Accumulator: written by software or by an operation's result.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         acc_reg <= mrs_pkg::ACC_RST;
      end
      else if (wr_fire & sel_acc & pstrb[0])
      begin
         acc_reg <= pwdata[7:0];
      end
      else if ((state_reg == mrs_pkg::ST_EXEC) & ex_to_acc)
      begin
         acc_reg <= ex_val;
      end
   end

   // Flags: software may preset the carry before a chained operation.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         flags_reg <= mrs_pkg::FLAGS_RST;
      end
      else if (wr_fire & sel_flags & pstrb[0])
      begin
         flags_reg <= pwdata[3:0];
      end
      else if (state_reg == mrs_pkg::ST_EXEC)
      begin
         flags_reg <= ex_flags;
      end
   end

   // Data memory operand store.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < mrs_pkg::MEM_WORDS; i++)
         begin
            mem_reg[i] <= mrs_pkg::MEM_RST;
         end
      end
      else if (wr_fire & sel_mem & pstrb[0])
      begin
         mem_reg[mem_idx] <= pwdata[7:0];
      end
      else if ((state_reg == mrs_pkg::ST_EXEC) & ex_to_mem)
      begin
         mem_reg[cmd_reg.addr] <= ex_val;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign busy = busy_reg;
   assign last_skip = skip_reg;

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   logic exec_now;
   assign exec_now = (state_reg == mrs_pkg::ST_EXEC);

   chk_rotl_carry_mem: assert property ( // RULE_01
      @(posedge clk_sys) disable iff (rst)
      exec_now && cmd_reg.op == mrs_pkg::OP_ROTL_CARRY_MEM |=>
      mem_reg[cmd_reg.addr] == {$past(operand[6:0]), $past(cin)} &&
      flags_reg.carry_flag == $past(operand[7]) &&
      flags_reg[3:1] == $past(flags_reg[3:1]))
      else $error("rotate left through carry wrong");

   chk_rotl_carry_acc: assert property ( // RULE_02
      @(posedge clk_sys) disable iff (rst)
      exec_now && cmd_reg.op == mrs_pkg::OP_ROTL_CARRY_ACC |=>
      acc_reg == {$past(operand[6:0]), $past(cin)} &&
      mem_reg[cmd_reg.addr] == $past(operand))
      else $error("rotate left to accumulator wrong");

   chk_rotr_flags_kept: assert property ( // RULE_03
      @(posedge clk_sys) disable iff (rst)
      exec_now && (cmd_reg.op == mrs_pkg::OP_ROTR_MEM ||
                   cmd_reg.op == mrs_pkg::OP_ROTR_ACC) |=>
      flags_reg == $past(flags_reg) && $past(ex_skip) == 1'b0)
      else $error("plain rotate changed flags");

   chk_rotr_carry_acc: assert property ( // RULE_06
      @(posedge clk_sys) disable iff (rst)
      exec_now && cmd_reg.op == mrs_pkg::OP_ROTR_CARRY_ACC |=>
      acc_reg == {$past(cin), $past(operand[7:1])} &&
      flags_reg.carry_flag == $past(operand[0]))
      else $error("rotate right through carry wrong");

   chk_sub_borrow_acc: assert property ( // RULE_07
      @(posedge clk_sys) disable iff (rst)
      exec_now && cmd_reg.op == mrs_pkg::OP_SUB_BORROW_ACC |=>
      {acc_reg, flags_reg} ==
      sub_add($past(acc_reg), $past(operand), $past(cin)))
      else $error("subtract with borrow wrong");

   chk_dec_skip_time: assert property ( // RULE_09
      @(posedge clk_sys) disable iff (rst)
      exec_now && cmd_reg.op == mrs_pkg::OP_DEC_SKIP_MEM &&
      operand == 8'h01 |=>
      state_reg == mrs_pkg::ST_DUMMY ##1 state_reg == mrs_pkg::ST_IDLE)
      else $error("decrement skip did not take two cycles");

   chk_inc_no_skip: assert property ( // RULE_13
      @(posedge clk_sys) disable iff (rst)
      exec_now && cmd_reg.op == mrs_pkg::OP_INC_SKIP_MEM &&
      operand != 8'hFF |=> state_reg == mrs_pkg::ST_IDLE && !skip_reg)
      else $error("increment skipped on nonzero result");

   chk_set_byte_ones: assert property ( // RULE_11
      @(posedge clk_sys) disable iff (rst)
      exec_now && cmd_reg.op == mrs_pkg::OP_SET_BYTE |=>
      mem_reg[cmd_reg.addr] == 8'hFF && $stable(flags_reg))
      else $error("set byte wrong");

   chk_skip_bit_set: assert property ( // RULE_15
      @(posedge clk_sys) disable iff (rst)
      exec_now && cmd_reg.op == mrs_pkg::OP_SKIP_BIT_SET |=>
      skip_reg == $past(operand[cmd_reg.bit_sel]) &&
      cycles_reg == (skip_reg ? 2'h2 : 2'h1))
      else $error("bit skip decision wrong");

   chk_swap_mem: assert property ( // RULE_19
      @(posedge clk_sys) disable iff (rst)
      exec_now && cmd_reg.op == mrs_pkg::OP_SWAP_MEM |=>
      mem_reg[cmd_reg.addr] == {$past(operand[3:0]), $past(operand[7:4])}
      && $stable(flags_reg))
      else $error("nibble swap wrong");

   chk_sub_zero_flag: assert property ( // RULE_21
      @(posedge clk_sys) disable iff (rst)
      exec_now && cmd_reg.op == mrs_pkg::OP_SUB_ACC |=>
      flags_reg.zero_flag == (acc_reg == 8'h00) &&
      flags_reg.carry_flag == ($past(acc_reg) >= $past(operand)))
      else $error("subtract zero or carry flag wrong");

endmodule : mrs_exec_core

/* File: mrs_exec_core_bench.sv */
// Purpose: Self-checking bench for the rotate, subtract and skip core.
// Assumes: The bench is the APB master; the core stalls reads until idle.
// Notes:   Each read notes its expected word; a monitor compares in order.
module mrs_exec_core_bench;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // Signals and bookkeeping.
   // ----------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready, pslverr, busy, last_skip;
   int errors = 0;
   int comparisons = 0;
   int seed = 32'h17c1_5086;
   int busy_cnt = 0;
   logic [32:0] exp_q[$];
   logic [32:0] exp_e;

   // Free-running 100 MHz clock.
   always #5 clk_sys = ~clk_sys;

   mrs_exec_core u_mrs_exec_core (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .busy(busy), .last_skip(last_skip));

   // ----------------------------------------------------------------
   // Helpers.
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      begin
         comparisons++;
         if (seen !== exp)
         begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
         end
      end
   endtask : check

   task close_out;
      begin
         $display("comparisons %0d errors %0d", comparisons, errors);
         if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask : close_out

   // One APB transfer; an edge passes first so psel never toggles twice.
   task automatic apb(input logic w, input logic [11:0] ad,
                      input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge clk_sys);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= ad;
         pwdata <= d;
         @(posedge clk_sys);
         penable <= 1'b1;
         @(posedge clk_sys);
         while (pready !== 1'b1 && n < 40)
         begin
            @(posedge clk_sys);
            n++;
         end
         if (n >= 40)
            errors++;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic rd(input logic [11:0] ad, input logic [31:0] e,
                     input logic err);
      begin
         exp_q.push_back({err, e});
         apb(1'b0, ad, 32'h0000_0000);
      end
   endtask : rd

   // Reference behaviour of one operation.
   task automatic model(input logic [4:0] op, input logic [7:0] a, m, x,
      input logic [3:0] f, input logic [2:0] b,
      output logic [7:0] na, nm, output logic [3:0] nf, output logic sk);
      logic [7:0] s;
      logic [8:0] r;
      logic [4:0] h;
      logic cin;
      begin
         na = a;
         nm = m;
         nf = f;
         sk = 1'b0;
         s = (op == 5'h11) ? ~x : ~m;
         cin = (op == 5'h06 || op == 5'h07) ? f[0] : 1'b1;
         r = {1'b0, a} + {1'b0, s} + {8'h00, cin};
         h = {1'b0, a[3:0]} + {1'b0, s[3:0]} + {4'h0, cin};
         case (op)
            5'h00: {nf[0], nm} = {m, f[0]};
            5'h01: {nf[0], na} = {m, f[0]};
            5'h02: nm = {m[0], m[7:1]};
            5'h03: na = {m[0], m[7:1]};
            5'h04: {nm, nf[0]} = {f[0], m};
            5'h05: {na, nf[0]} = {f[0], m};
            5'h08: nm = m - 8'h01;
            5'h09: na = m - 8'h01;
            5'h0a: nm = 8'hff;
            5'h0b: nm[b] = 1'b1;
            5'h0c: nm = m + 8'h01;
            5'h0d: na = m + 8'h01;
            5'h0e: sk = m[b];
            5'h12: nm = {m[3:0], m[7:4]};
            5'h13: na = {m[3:0], m[7:4]};
            default: ;
         endcase
         if (op == 5'h08 || op == 5'h0c)
            sk = (nm == 8'h00);
         if (op == 5'h09 || op == 5'h0d)
            sk = (na == 8'h00);
         if (op == 5'h06 || op == 5'h07 || op == 5'h0f || op == 5'h10 ||
             op == 5'h11)
         begin
            nf = {a[7] == s[7] && r[7] != a[7], r[7:0] == 8'h00, h[4], r[8]};
            if (op == 5'h07 || op == 5'h10)
               nm = r[7:0];
            else
               na = r[7:0];
         end
      end
   endtask : model

   // Loads operands, starts one operation and reads back every effect.
   task automatic run_op(input int p, input logic [4:0] op);
      logic [7:0] a, m, x, na, nm;
      logic [3:0] f, nf, ad;
      logic [2:0] b;
      logic sk;
      logic [11:0] ma;
      begin
         a = 8'($random(seed));
         x = 8'($random(seed));
         f = 4'($random(seed));
         ad = 4'($random(seed));
         b = 3'($random(seed));
         m = (p == 0) ? 8'($random(seed)) : ((p == 1) ? 8'h01 : 8'hff);
         ma = mrs_pkg::ADDR_MEM_BASE + {6'h00, ad, 2'b00};
         apb(1'b1, ma, {24'h00_0000, m});
         apb(1'b1, mrs_pkg::ADDR_ACC, {24'h00_0000, a});
         apb(1'b1, mrs_pkg::ADDR_FLAGS, {28'h000_0000, f});
         busy_cnt = 0;
         apb(1'b1, mrs_pkg::ADDR_CMD, {x, 4'h0, ad, 5'h00, b, 3'h0, op});
         model(op, a, m, x, f, b, na, nm, nf, sk);
         rd(mrs_pkg::ADDR_ACC, {24'h00_0000, na}, 1'b0);
         rd(mrs_pkg::ADDR_FLAGS, {28'h000_0000, nf}, 1'b0);
         rd(ma, {24'h00_0000, nm}, 1'b0);
         if (op <= mrs_pkg::OP_LAST)
         begin
            rd(mrs_pkg::ADDR_STATUS, {26'h000_0000, sk ? mrs_pkg::CYC_SKIP :
               mrs_pkg::CYC_PLAIN, 2'b00, sk, 1'b0}, 1'b0);
            check(32'(busy_cnt), sk ? 32'h0000_0002 : 32'h0000_0001);
            check({31'h0000_0000, last_skip}, {31'h0000_0000, sk});
         end
      end
   endtask : run_op

   // ----------------------------------------------------------------
   // Monitor, busy counter, watchdog and main sequence.
   // ----------------------------------------------------------------
   // Pops the oldest note whenever a read completes.
   always @(posedge clk_sys)
   begin
      if (psel && penable && !pwrite && pready === 1'b1)
      begin
         exp_e = exp_q.pop_front();
         check(prdata, exp_e[31:0]);
         check({31'h0000_0000, pslverr}, {31'h0000_0000, exp_e[32]});
      end
   end

   // Counts execution cycles so that skip timing is seen at the port.
   always @(posedge clk_sys)
   begin
      if (busy === 1'b1)
         busy_cnt <= busy_cnt + 1;
   end

   // About 63 operations of some 32 cycles each; 100 us leaves margin.
   initial
   begin
      #100us;
      errors++;
      close_out();
   end

   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      rd(mrs_pkg::ADDR_ACC, 32'h0000_0000, 1'b0);
      rd(mrs_pkg::ADDR_STATUS, 32'h0000_0000, 1'b0);
      rd(12'h010, 32'h0000_0000, 1'b1);
      // Random operands, then 01 and ff to reach both skip outcomes.
      for (int p = 0; p < 3; p++)
         for (int o = 0; o <= 20; o++)
            run_op(p, 5'(o));
      repeat (4) @(posedge clk_sys);
      close_out();
   end
endmodule : mrs_exec_core_bench
